/* orm_defs.svh */
// Purpose: Constants for the over-range flag and aux clock output block
// Assumes: Included by the top, checker and bench modules of the block
// Notes:   Register indices, field positions and reset values
//
// Functional notes
// R1 - Channel A flag high while input exceeds threshold
// R2 - Each flag holds at least the minimum length
// R3 - Channel B flag only on dual/quad builds
// R4 - Channels C/D flags only on quad builds
// R5 - C pin carries clock when enabled, PLL on
// R6 - Straps zero or PLL off: C/D flags
// R7 - Config 1/2/3 gives divide 1/2/4 on C
// R8 - C clock from power-up by straps alone
// R9 - D carries undivided clock when any strap set
// R10 - D half/quarter rate only by register override
// R11 - D clock only while C outputs a clock
// R12 - Power-down stops reference and C/D clocks
// R13 - Reference output repeats the selected reference input
// R14 - PLL enable high turns PLL on, else bypass
// R15 - Flag drops after length elapsed since exceedance
`ifndef ORM_DEFS_SVH
`define ORM_DEFS_SVH

`define ORM_ADDR_THRESH   4'h0
`define ORM_ADDR_MINLEN   4'h1
`define ORM_ADDR_CLKCTL   4'h2
`define ORM_ADDR_STATUS   4'h3
`define ORM_ADDR_CLEAR    4'h4
`define ORM_ADDR_ENABLE   4'h5
`define ORM_ADDR_LIVE     4'h6

`define ORM_THRESH_RST    12'hE00
`define ORM_MINLEN_RST    8'h04
`define ORM_CLKCTL_RST    5'h00

`define ORM_CTL_OVR_BIT   0
`define ORM_CTL_C_LSB     1
`define ORM_CTL_D_LSB     3
`define ORM_SEL_W         2
`define ORM_CTL_W         5
`define ORM_LIVE_W        10

`define ORM_EVT_W         5
`define ORM_EVT_CSTOP     4

`endif

/* orm_pkg.sv */
// Purpose: Types shared by the over-range flag and aux clock block
// Assumes: Nothing
// Notes:   Enum order matches the two-bit clock configuration code
`default_nettype none
package orm_pkg;
	typedef enum logic [1:0] {CS_OFF, CS_DIV1, CS_DIV2, CS_DIV4} orm_clksel_type;
	typedef enum logic [1:0] {ST_HOLD, ST_LATCH, ST_RUN} orm_state_type;
endpackage
`default_nettype wire

/* orm_flag.sv */
// Purpose: One channel over-range detector with minimum pulse stretch
// Assumes: Magnitude input synchronous to clock
// Notes:   Flag stays high min_len + 1 cycles after last exceedance
`default_nettype none
module orm_flag #(
	parameter int DW = 12,
	parameter int LW = 8
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic [DW-1:0] mag,
	input  wire logic [DW-1:0] threshold,
	input  wire logic [LW-1:0] min_len,
	output var  logic          flag_q,
	output var  logic          rise_q
);
	logic [LW-1:0] cnt_q;
	logic          exceed;

	assign exceed = mag > threshold;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (exceed) begin
			cnt_q <= min_len; // R2
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1; // R15
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			flag_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			flag_q <= exceed || (cnt_q != '0); // R1 R15
			rise_q <= exceed && !flag_q;
		end
	end
endmodule // orm_flag
`default_nettype wire

/* orm_clkdiv.sv */
// Purpose: Half and quarter rate copies of the sampled reference level
// Assumes: Reference toggles slower than half the clock rate
// Notes:   Held low while disabled so copies restart in phase
`default_nettype none
module orm_clkdiv (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic ref_lvl,
	output var  logic div2_q,
	output var  logic div4_q
);
	logic prev_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= ref_lvl;
		end
	end

	always_ff @(posedge clock) begin
		if (rst || !enable) begin
			div2_q <= 1'b0;
			div4_q <= 1'b0;
		end else if (ref_lvl && !prev_q) begin
			div2_q <= !div2_q;
			if (div2_q) begin
				div4_q <= !div4_q;
			end
		end
	end
endmodule // orm_clkdiv
`default_nettype wire

/* orm_top.sv */
// Purpose: Over-range status outputs with aux clock muxing on C and D
// Assumes: All pins synchronous to clock; reference sampled as a level
// Notes:   Straps are caught on the first cycle after reset release
`include "orm_defs.svh"
`default_nettype none
module orm_top #(
	parameter int NUM_CH = 4,
	parameter int DW     = 12,
	parameter int LW     = 8
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic [3:0]    reg_addr,
	input  wire logic [15:0]   reg_wdata,
	input  wire logic          reg_write,
	input  wire logic          reg_read,
	output var  logic [15:0]   reg_rdata,
	input  wire logic [DW-1:0] chan_a_mag,
	input  wire logic [DW-1:0] chan_b_mag,
	input  wire logic [DW-1:0] chan_c_mag,
	input  wire logic [DW-1:0] chan_d_mag,
	input  wire logic          ref_clk_diff_in,
	input  wire logic          ref_clk_se_in,
	input  wire logic          ref_sel_se_pin,
	input  wire logic          pll_enable_pin,
	input  wire logic          power_down_pin,
	input  wire logic          aux_clock_strap_bit0,
	input  wire logic          aux_clock_strap_bit1,
	output var  logic          chan_a_overrange_out,
	output var  logic          chan_b_overrange_out,
	output var  logic          chan_c_overrange_or_clk_out,
	output var  logic          chan_d_overrange_or_clk_out,
	output var  logic          ref_clock_repeat_out,
	output var  logic          pll_active_out,
	output var  logic          pll_bypass_out,
	output var  logic          irq_out
);
	import orm_pkg::*;

	////////////////////////////////////////////////////////////////
	// Parameter checks
	generate
		if (NUM_CH != 1 && NUM_CH != 2 && NUM_CH != 4) begin : g_bad_ch
			$error("NUM_CH must be 1, 2 or 4");
		end
		if (DW < 1 || DW > 16 || LW < 1 || LW > 16) begin : g_bad_w
			$error("DW and LW must be 1 to 16");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Declarations
	logic [DW-1:0]             thresh_q;
	logic [LW-1:0]             minlen_q;
	logic [`ORM_CTL_W-1:0]     clkctl_q;
	logic [`ORM_EVT_W-1:0]     status_q;
	logic [`ORM_EVT_W-1:0]     enable_q;
	logic [`ORM_EVT_W-1:0]     clear;
	logic [`ORM_EVT_W-1:0]     events;
	logic [1:0]                strap_q;
	orm_state_type             state_q;
	orm_clksel_type            sel_c;
	orm_clksel_type            sel_d;
	logic                      override;
	logic                      clk_c_on;
	logic                      clk_d_on;
	logic                      clk_c_on_q;
	logic                      ref_lvl_q;
	logic                      div2;
	logic                      div4;
	logic                      clk_c_val;
	logic                      clk_d_val;
	logic [DW-1:0]             mag_arr [4];
	logic [3:0]                flag;
	logic [3:0]                rise;
	logic [15:0]               rdata_d;

	assign mag_arr[0] = chan_a_mag;
	assign mag_arr[1] = chan_b_mag;
	assign mag_arr[2] = chan_c_mag;
	assign mag_arr[3] = chan_d_mag;

	////////////////////////////////////////////////////////////////
	// Start-up sequence: straps sampled once, after reset is gone
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= ST_HOLD;
		end else begin
			case (state_q)
				ST_HOLD:  state_q <= ST_LATCH;
				ST_LATCH: state_q <= ST_RUN;
				ST_RUN:   state_q <= ST_RUN;
				default:  state_q <= ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			strap_q <= 2'h0;
		end else if (state_q == ST_HOLD) begin
			strap_q <= {aux_clock_strap_bit1, aux_clock_strap_bit0}; // R8
		end
	end

	////////////////////////////////////////////////////////////////
	// Per-channel over-range detectors; absent channels read low
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			if (i < NUM_CH) begin : g_on // R3 R4
				orm_flag #(
					.DW (DW),
					.LW (LW)
				) u_flag (
					.clock     (clock),
					.rst       (rst),
					.mag       (mag_arr[i]),
					.threshold (thresh_q),
					.min_len   (minlen_q),
					.flag_q    (flag[i]),
					.rise_q    (rise[i])
				);
			end else begin : g_off
				assign flag[i] = 1'b0;
				assign rise[i] = 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Reference repeat and dividers
	always_ff @(posedge clock) begin
		if (rst) begin
			ref_lvl_q <= 1'b0;
		end else begin
			ref_lvl_q <= ref_sel_se_pin ? ref_clk_se_in : ref_clk_diff_in; // R13
		end
	end

	orm_clkdiv u_div (
		.clock   (clock),
		.rst     (rst),
		.enable  (clk_c_on),
		.ref_lvl (ref_lvl_q),
		.div2_q  (div2),
		.div4_q  (div4)
	);

	////////////////////////////////////////////////////////////////
	// Clock source selection
	// Override bit hands both pins to software; straps stay latched.
	always_comb begin
		override = clkctl_q[`ORM_CTL_OVR_BIT];
		if (override) begin
			sel_c = orm_clksel_type'(clkctl_q[`ORM_CTL_C_LSB +: `ORM_SEL_W]);
			sel_d = orm_clksel_type'(clkctl_q[`ORM_CTL_D_LSB +: `ORM_SEL_W]); // R10
		end else if (state_q == ST_RUN) begin
			sel_c = orm_clksel_type'(strap_q); // R7 R8
			sel_d = (strap_q != 2'h0) ? CS_DIV1 : CS_OFF; // R9
		end else begin
			sel_c = CS_OFF;
			sel_d = CS_OFF;
		end
	end

	assign clk_c_on = (sel_c != CS_OFF) && pll_enable_pin
		&& !power_down_pin; // R5 R6 R12
	assign clk_d_on = clk_c_on && (sel_d != CS_OFF); // R11

	always_comb begin
		case (sel_c)
			CS_DIV1: clk_c_val = ref_lvl_q; // R7
			CS_DIV2: clk_c_val = div2;
			CS_DIV4: clk_c_val = div4;
			default: clk_c_val = 1'b0;
		endcase
	end

	always_comb begin
		case (sel_d)
			CS_DIV1: clk_d_val = ref_lvl_q;
			CS_DIV2: clk_d_val = div2;
			CS_DIV4: clk_d_val = div4;
			default: clk_d_val = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Output pins
	always_ff @(posedge clock) begin
		if (rst) begin
			chan_a_overrange_out        <= 1'b0;
			chan_b_overrange_out        <= 1'b0;
			chan_c_overrange_or_clk_out <= 1'b0;
			chan_d_overrange_or_clk_out <= 1'b0;
		end else begin
			chan_a_overrange_out <= flag[0]; // R1
			chan_b_overrange_out <= flag[1]; // R3
			chan_c_overrange_or_clk_out <= clk_c_on ? clk_c_val
				: flag[2]; // R5 R6
			chan_d_overrange_or_clk_out <= clk_d_on ? clk_d_val
				: (clk_c_on ? 1'b0 : flag[3]); // R6 R11
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ref_clock_repeat_out <= 1'b0;
		end else begin
			ref_clock_repeat_out <= ref_lvl_q && !power_down_pin; // R12 R13
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pll_active_out <= 1'b0;
			pll_bypass_out <= 1'b1;
		end else begin
			pll_active_out <= pll_enable_pin; // R14
			pll_bypass_out <= !pll_enable_pin; // R14
		end
	end

	////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clock) begin
		if (rst) begin
			thresh_q <= DW'(`ORM_THRESH_RST);
			minlen_q <= LW'(`ORM_MINLEN_RST);
			clkctl_q <= `ORM_CLKCTL_RST;
			enable_q <= '0;
		end else if (reg_write) begin
			case (reg_addr)
				`ORM_ADDR_THRESH: thresh_q <= reg_wdata[DW-1:0];
				`ORM_ADDR_MINLEN: minlen_q <= reg_wdata[LW-1:0];
				`ORM_ADDR_CLKCTL: clkctl_q <= reg_wdata[`ORM_CTL_W-1:0];
				`ORM_ADDR_ENABLE: enable_q <= reg_wdata[`ORM_EVT_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status: a set in the clearing cycle is kept
	always_ff @(posedge clock) begin
		if (rst) begin
			clk_c_on_q <= 1'b0;
		end else begin
			clk_c_on_q <= clk_c_on;
		end
	end

	assign clear = (reg_write && reg_addr == `ORM_ADDR_CLEAR)
		? reg_wdata[`ORM_EVT_W-1:0] : '0;
	assign events = {clk_c_on_q && !clk_c_on, rise};

	always_ff @(posedge clock) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			status_q <= (status_q & ~clear) | events;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(((status_q & ~clear) | events) & enable_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// Register reads; unmapped and write-only read as zero
	always_comb begin
		rdata_d = 16'h0000;
		case (reg_addr)
			`ORM_ADDR_THRESH: rdata_d[DW-1:0] = thresh_q;
			`ORM_ADDR_MINLEN: rdata_d[LW-1:0] = minlen_q;
			`ORM_ADDR_CLKCTL: rdata_d[`ORM_CTL_W-1:0] = clkctl_q;
			`ORM_ADDR_STATUS: rdata_d[`ORM_EVT_W-1:0] = status_q;
			`ORM_ADDR_ENABLE: rdata_d[`ORM_EVT_W-1:0] = enable_q;
			`ORM_ADDR_LIVE:   rdata_d[`ORM_LIVE_W-1:0] = {strap_q,
				pll_enable_pin,
				clk_d_on, clk_c_on, power_down_pin, flag};
			default:          rdata_d = 16'h0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule // orm_top
`default_nettype wire

/* orm_chk.sv */
// Purpose: Port checks for the over-range and aux clock block
// Assumes: Four channel build, one clock
// Notes:   Threshold and length shadowed from register writes
`include "orm_defs.svh"
`default_nettype none
module orm_chk #(
	parameter int DW = 12,
	parameter int LW = 8
) (
	input wire logic          clock,
	input wire logic          rst,
	input wire logic [3:0]    reg_addr,
	input wire logic [15:0]   reg_wdata,
	input wire logic          reg_write,
	input wire logic          reg_read,
	input wire logic [15:0]   reg_rdata,
	input wire logic [DW-1:0] chan_a_mag,
	input wire logic [DW-1:0] chan_c_mag,
	input wire logic          pll_enable_pin,
	input wire logic          power_down_pin,
	input wire logic          chan_a_overrange_out,
	input wire logic          chan_c_overrange_or_clk_out,
	input wire logic          ref_clock_repeat_out,
	input wire logic          pll_active_out,
	input wire logic          pll_bypass_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DW-1:0] thr_q;
	logic [LW-1:0] len_q;
	logic [9:0]    quiet_q;
	always_ff @(posedge clock) begin
		if (rst) begin
			thr_q <= DW'(`ORM_THRESH_RST);
			len_q <= LW'(`ORM_MINLEN_RST);
		end else if (reg_write) begin
			if (reg_addr == `ORM_ADDR_THRESH)
				thr_q <= reg_wdata[DW-1:0];
			if (reg_addr == `ORM_ADDR_MINLEN)
				len_q <= reg_wdata[LW-1:0];
		end
	end
	// Saturates so a long quiet spell never wraps
	always_ff @(posedge clock) begin
		if (rst || chan_a_mag > thr_q)
			quiet_q <= 10'h000;
		else if (quiet_q != 10'h3FF)
			quiet_q <= quiet_q + 10'h001;
	end
	////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_a_rise: assert property (
		chan_a_mag > thr_q |-> ##2 chan_a_overrange_out)
		else $error("flag A missed an exceedance");
	chk_a_hold: assert property (
		$rose(chan_a_overrange_out) && len_q != 0 |=> chan_a_overrange_out)
		else $error("flag A pulse too short");
	// Slack of four covers the output stage
	chk_a_drop: assert property (
		quiet_q > 10'(len_q) + 10'h004 |-> !chan_a_overrange_out)
		else $error("flag A held too long");
	chk_c_flag: assert property (
		(!pll_enable_pin)[*3] ##0 chan_c_mag > thr_q
		##1 (!pll_enable_pin)[*2] |-> chan_c_overrange_or_clk_out)
		else $error("pin C did not carry its flag");
	chk_ref_pd: assert property (
		power_down_pin |=> !ref_clock_repeat_out)
		else $error("reference out runs in power down");
	chk_pll_act: assert property (
		!$past(rst) |-> pll_active_out == $past(pll_enable_pin))
		else $error("PLL active does not follow enable");
	chk_pll_byp: assert property (
		pll_bypass_out != pll_active_out)
		else $error("PLL bypass not inverse of active");
	chk_rdata_idle: assert property (
		!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside read slot");
	cover property ($rose(chan_a_overrange_out));
	cover property ($rose(chan_c_overrange_or_clk_out) && pll_enable_pin);
	cover property (power_down_pin && pll_enable_pin);
endmodule // orm_chk
`default_nettype wire

/* orm_host.sv */
// Purpose: Host side model counting rising edges on received clocks
// Assumes: Pins sampled on the block clock
// Notes:   Counts wrap at 256, windows are kept short
`default_nettype none
module orm_host (
	input  wire logic            clock,
	input  wire logic            clr,
	input  wire logic [2:0]      pins,
	output var  logic [2:0][7:0] edges
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] prev_q;
	////////////////////////////////////////
	always_ff @(posedge clock) begin
		prev_q <= pins;
		for (int i = 0; i < 3; i++) begin
			if (clr)
				edges[i] <= 8'h00;
			else if (pins[i] && !prev_q[i])
				edges[i] <= edges[i] + 8'h01;
		end
	end
endmodule // orm_host
`default_nettype wire

/* orm_tb.sv */
// Purpose: Self-checking bench for the over-range and aux clock block
// Assumes: Diff reference period 8 cycles, single-ended period 4
// Notes:   Edge windows are 64 cycles so counts are exact
`include "orm_defs.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic            clock = 1'b0;
	logic            rst = 1'b1;
	logic [3:0]      reg_addr = 4'h0;
	logic [15:0]     reg_wdata = 16'h0000;
	logic            reg_write = 1'b0;
	logic            reg_read = 1'b0;
	logic [15:0]     reg_rdata;
	logic [11:0]     chan_a_mag = 12'h000, chan_b_mag = 12'h000;
	logic [11:0]     chan_c_mag = 12'h000, chan_d_mag = 12'h000;
	logic            ref_clk_diff_in = 1'b0, ref_clk_se_in = 1'b0;
	logic            ref_sel_se_pin = 1'b0, pll_enable_pin = 1'b0;
	logic            power_down_pin = 1'b0, aux_clock_strap_bit0 = 1'b0;
	logic            aux_clock_strap_bit1 = 1'b0;
	logic            chan_a_overrange_out, chan_b_overrange_out;
	logic            chan_c_overrange_or_clk_out, chan_d_overrange_or_clk_out;
	logic            ref_clock_repeat_out, pll_active_out;
	logic            pll_bypass_out, irq_out;
	logic [2:0]      rc = 3'h0;
	logic            clr = 1'b0;
	logic [2:0][7:0] edges;
	int              errors = 0;
	int              comparisons = 0;

	always #5 clock = ~clock;
	always @(posedge clock) begin
		rc <= rc + 3'h1;
		ref_clk_diff_in <= rc[2];
		ref_clk_se_in <= rc[1];
	end
	orm_top uut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .chan_a_mag, .chan_b_mag, .chan_c_mag, .chan_d_mag,
		.ref_clk_diff_in, .ref_clk_se_in, .ref_sel_se_pin, .pll_enable_pin,
		.power_down_pin, .aux_clock_strap_bit0, .aux_clock_strap_bit1,
		.chan_a_overrange_out, .chan_b_overrange_out,
		.chan_c_overrange_or_clk_out, .chan_d_overrange_or_clk_out,
		.ref_clock_repeat_out, .pll_active_out, .pll_bypass_out, .irq_out);
	orm_host host (.clock, .clr, .edges, .pins({ref_clock_repeat_out,
		chan_d_overrange_or_clk_out, chan_c_overrange_or_clk_out}));
	////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [15:0] m, e);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		check(reg_rdata & m, e);
		@(posedge clock);
	endtask
	task automatic pins(input logic [15:0] e);
		cyc(2);
		@(negedge clock);
		check(16'({pll_active_out, pll_bypass_out, irq_out}), e);
		// Back on a rising edge so the next drive follows it
		@(posedge clock);
	endtask
	task automatic cnt(input logic [7:0] ec, ed, er);
		cyc(16);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		cyc(64);
		@(negedge clock);
		check(16'(edges[0]), 16'(ec));
		check(16'(edges[1]), 16'(ed));
		check(16'(edges[2]), 16'(er));
		@(posedge clock);
	endtask
	task automatic set_mag(input logic [11:0] v);
		chan_a_mag <= v;
		chan_b_mag <= v;
		chan_c_mag <= v;
		chan_d_mag <= v;
	endtask
	task automatic do_reset(input logic [1:0] s);
		{aux_clock_strap_bit1, aux_clock_strap_bit0} <= s;
		rst <= 1'b1;
		cyc(5);
		rst <= 1'b0;
		cyc(30);
	endtask
	task automatic stop_test;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_regs;
		rdc(`ORM_ADDR_THRESH, 16'hFFFF, 16'(`ORM_THRESH_RST));
		rdc(`ORM_ADDR_MINLEN, 16'hFFFF, 16'(`ORM_MINLEN_RST));
		rdc(`ORM_ADDR_CLEAR, 16'hFFFF, 16'h0000);
		rdc(4'hF, 16'hFFFF, 16'h0000);
		pins(16'h0002);
		pll_enable_pin <= 1'b1;
		pins(16'h0004);
		pll_enable_pin <= 1'b0;
	endtask
	task automatic t_flags;
		logic [3:0] seen;
		int         n;
		seen = 4'h0;
		n = 0;
		wr(`ORM_ADDR_THRESH, 16'h0100);
		wr(`ORM_ADDR_MINLEN, 16'h0003);
		set_mag(12'h101);
		@(posedge clock);
		set_mag(12'h100);
		repeat (16) begin
			@(negedge clock);
			seen |= {chan_a_overrange_out, chan_b_overrange_out,
				chan_c_overrange_or_clk_out, chan_d_overrange_or_clk_out};
			if (chan_a_overrange_out === 1'b1)
				n++;
		end
		check(16'(seen), 16'h000F);
		check(16'(n >= 4 && n <= 6), 16'h0001);
		rdc(`ORM_ADDR_STATUS, 16'h000F, 16'h000F);
		pins(16'h0002);
		wr(`ORM_ADDR_ENABLE, 16'h000F);
		pins(16'h0003);
		rdc(`ORM_ADDR_ENABLE, 16'hFFFF, 16'h000F);
		wr(`ORM_ADDR_CLEAR, 16'h001F);
		pins(16'h0002);
		rdc(`ORM_ADDR_STATUS, 16'h000F, 16'h0000);
	endtask
	task automatic t_clocks;
		pll_enable_pin <= 1'b1;
		for (int s = 1; s < 4; s++) begin
			do_reset(2'(s));
			cnt(8'(8'h08 >> (s - 1)), 8'h08, 8'h08);
		end
		ref_sel_se_pin <= 1'b1;
		cnt(8'h04, 8'h10, 8'h10);
		ref_sel_se_pin <= 1'b0;
	endtask
	task automatic t_override;
		wr(`ORM_ADDR_CLKCTL, 16'h0013);
		cnt(8'h08, 8'h04, 8'h08);
		wr(`ORM_ADDR_CLKCTL, 16'h001B);
		cnt(8'h08, 8'h02, 8'h08);
		wr(`ORM_ADDR_CLKCTL, 16'h0009);
		cnt(8'h00, 8'h00, 8'h08);
		rdc(`ORM_ADDR_CLKCTL, 16'hFFFF, 16'h0009);
		rdc(`ORM_ADDR_LIVE, 16'h03FF, 16'h0380);
	endtask
	task automatic t_power;
		wr(`ORM_ADDR_CLKCTL, 16'h0013);
		wr(`ORM_ADDR_CLEAR, 16'h001F);
		power_down_pin <= 1'b1;
		cnt(8'h00, 8'h00, 8'h00);
		rdc(`ORM_ADDR_STATUS, 16'h0010, 16'h0010);
		rdc(`ORM_ADDR_LIVE, 16'h03FF, 16'h0390);
		power_down_pin <= 1'b0;
		pll_enable_pin <= 1'b0;
		cnt(8'h00, 8'h00, 8'h08);
	endtask
	initial begin
		do_reset(2'b00);
		t_regs();
		t_flags();
		t_clocks();
		t_override();
		t_power();
		stop_test();
	end
	// Whole run needs about 950 cycles
	initial begin
		cyc(6000);
		errors++;
		stop_test();
	end
endmodule // tb
bind orm_top orm_chk #(.DW(DW), .LW(LW)) chk_i (.clock, .rst, .reg_addr,
	.reg_wdata, .reg_write, .reg_read, .reg_rdata, .chan_a_mag, .chan_c_mag,
	.pll_enable_pin, .power_down_pin, .chan_a_overrange_out,
	.chan_c_overrange_or_clk_out, .ref_clock_repeat_out, .pll_active_out,
	.pll_bypass_out);
`default_nettype wire
